// [design/flash_cmd_consts.svh]
`ifndef FLASH_CMD_CONSTS_SVH
`define FLASH_CMD_CONSTS_SVH

// command opcodes
`define OP_QUAD_ENTER      8'h38
`define OP_QUAD_EXIT       8'hFF
`define OP_RESET_ARM       8'h66
`define OP_RESET_GO        8'h99

// recovery times, printed units
`define RST_RECOVER_US     30
`define RST_ERASE_MS       12
`define CLK_MHZ            10
// cycles: exact products of time and clock, nothing rounds
`define RST_RECOVER_CYC    (`RST_RECOVER_US * `CLK_MHZ)
`define RST_ERASE_CYC      (`RST_ERASE_MS * 1000 * `CLK_MHZ)

// reset / delivery values
`define STATUS_RESET       8'h00
`define ARRAY_ERASED       8'hFF
`define READ_PARAM_RESET   8'h00
`define CONT_MODE_RESET    8'h00
`define WRAP_RESET         3'h7

`endif

// [design/flash_cmd_pkg.sv]
package flash_cmd_pkg;
   // command decoded at the end of a link frame
   typedef struct packed {
      logic       valid;
      logic [7:0] opcode;
   } frame_cmd_t;

   // volatile settings cleared by reset, except wrap bits set to 3'h7
   typedef struct packed {
      logic [7:0] status;
      logic       write_enable_latch;
      logic       suspend_status_bit;
      logic [7:0] read_parameter_field;
      logic [7:0] continuous_read_mode_byte;
      logic [2:0] wrap_setting_bits;
      logic       deep_power_down;
   } volatile_t;

   typedef enum logic [1:0] {
      ST_IDLE    = 2'b00,
      ST_ARMED   = 2'b01,
      ST_RECOVER = 2'b10
   } rst_state_t;
endpackage

// [design/link_frame_rx.sv]
`timescale 1ns/10ps
`include "flash_cmd_consts.svh"

// captures first command byte of each frame on the link clock,
// hands it to clk_i domain with a toggle crossing
module link_frame_rx (
   // system side
   input  wire logic                      clk_i,
   input  wire logic                      rst_i,
   input  wire logic                      quad_mode_i,
   output flash_cmd_pkg::frame_cmd_t      cmd_o,
   // link side
   input  wire logic                      sclk_i,
   input  wire logic                      cs_n_i,
   input  wire logic [3:0]                io_i
);
   ////////////////////////////////////////////////////////////
   // link domain, bit count, shift and done reset by cs_n high (clock only runs in frames)
   logic [2:0] bit_cnt_r;
   logic [7:0] shift_r;
   logic [7:0] byte_r;
   logic       tog_r;
   logic       done_r;
   logic       quad_lk_r;
   wire  [2:0] step = quad_lk_r ? 3'd4 : 3'd1;
   wire  [7:0] shift_nxt = quad_lk_r ? {shift_r[3:0], io_i} : {shift_r[6:0], io_i[0]};
   wire        last_bits = quad_lk_r ? (bit_cnt_r == 3'd4) : (bit_cnt_r == 3'd7);

   // mode taken as each frame opens: a sync on sclk_i would lag, since the
   // link clock stands still between frames; mode only moves while cs_n is high
   always_ff @(negedge cs_n_i) begin
      quad_lk_r <= quad_mode_i;
   end

   // only first byte of frame is the opcode
   always_ff @(posedge sclk_i or posedge cs_n_i) begin
      if (cs_n_i) begin
         bit_cnt_r <= 3'd0;
         shift_r   <= 8'h00;
         done_r    <= 1'b0;
      end else if (!done_r) begin
         shift_r   <= shift_nxt;
         bit_cnt_r <= bit_cnt_r + step;
         done_r    <= last_bits;
      end
   end

   // byte stands still until next frame's byte completes
   // toggle needs a known start, else the crossing never settles
   always_ff @(posedge sclk_i or posedge rst_i) begin
      if (rst_i) begin
         byte_r <= 8'h00;
         tog_r  <= 1'b0;
      end else if (!done_r && last_bits && !cs_n_i) begin
         byte_r <= shift_nxt;
         tog_r  <= ~tog_r;
      end
   end

   ////////////////////////////////////////////////////////////
   // system domain: toggle synchroniser plus cs_n level sync
   logic [2:0] tog_sync_r;
   logic [1:0] cs_sync_r;
   logic       pend_r;
   logic [7:0] hold_r;
   wire        got_byte = tog_sync_r[2] ^ tog_sync_r[1];
   wire        frame_end = cs_sync_r[1];

   always_ff @(posedge clk_i) begin
      tog_sync_r <= {tog_sync_r[1:0], tog_r};
      cs_sync_r  <= {cs_sync_r[0], cs_n_i};
   end

   // command acts at cs_n high, as a flash does
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pend_r <= 1'b0;
         hold_r <= 8'h00;
         cmd_o  <= '0;
      end else begin
         cmd_o.valid <= 1'b0;
         if (got_byte) begin
            pend_r <= 1'b1;
            hold_r <= byte_r;
         end else if (pend_r && frame_end) begin
            pend_r       <= 1'b0;
            cmd_o.valid  <= 1'b1;
            cmd_o.opcode <= hold_r;
         end
      end
   end
endmodule

// [design/flash_qpi_reset_ctl.sv]
`timescale 1ns/10ps
`include "flash_cmd_consts.svh"

module flash_qpi_reset_ctl #(
   parameter int unsigned RECOVER_CYC = `RST_RECOVER_CYC,
   parameter int unsigned ERASE_CYC   = `RST_ERASE_CYC
) (
   // system
   input  wire logic                       clk_i,
   input  wire logic                       rst_i,
   // link pins
   input  wire logic                       sclk_i,
   input  wire logic                       cs_n_i,
   input  wire logic [3:0]                 io_i,
   // rest of device: state and updates
   input  wire logic                       quad_enable_bit_i,
   input  wire logic                       busy_i,
   input  wire logic                       erase_active_i,
   input  wire logic                       set_write_enable_latch_i,
   input  wire logic                       set_suspend_status_bit_i,
   input  wire logic                       load_settings_i,
   input  flash_cmd_pkg::volatile_t        settings_i,
   // outputs
   output logic                            quad_mode_o,
   output flash_cmd_pkg::volatile_t        settings_o,
   output logic                            abort_o,
   output logic                            recovering_o,
   output logic                            cmd_valid_o,
   output logic [7:0]                      cmd_opcode_o,
   output logic                            integrity_lost_o,
   output logic [7:0]                      erased_byte_o
);
   flash_cmd_pkg::frame_cmd_t  cmd;
   flash_cmd_pkg::rst_state_t  state_r;
   flash_cmd_pkg::rst_state_t  state_nxt;
   logic [23:0]                rec_cnt_r;
   logic [23:0]                rec_cnt_nxt;
   logic [1:0]                 qe_sync_r;

   ////////////////////////////////////////////////////////////
   // frame receiver with link clock crossing
   link_frame_rx u_rx (
      .clk_i       (clk_i),
      .rst_i       (rst_i),
      .quad_mode_i (quad_mode_o),
      .cmd_o       (cmd),
      .sclk_i      (sclk_i),
      .cs_n_i      (cs_n_i),
      .io_i        (io_i)
   );

   // quad enable may come from a slow store, synchronised anyway
   always_ff @(posedge clk_i) begin
      qe_sync_r <= {qe_sync_r[0], quad_enable_bit_i};
   end

   ////////////////////////////////////////////////////////////
   // decode, gated off while recovering except qe_refuse, long_wait and rec_done
   wire live      = cmd.valid && (state_r != flash_cmd_pkg::ST_RECOVER);
   wire is_arm    = live && cmd.opcode == `OP_RESET_ARM;
   wire is_go     = live && cmd.opcode == `OP_RESET_GO;
   wire accept    = is_go && state_r == flash_cmd_pkg::ST_ARMED;
   wire q_enter   = live && cmd.opcode == `OP_QUAD_ENTER && qe_sync_r[1];
   wire q_exit    = live && cmd.opcode == `OP_QUAD_EXIT;
   // refused commands never reach the rest of the device
   wire qe_refuse = cmd.opcode == `OP_QUAD_ENTER && !qe_sync_r[1];
   wire go_refuse = is_go && state_r != flash_cmd_pkg::ST_ARMED;
   wire refused   = qe_refuse || go_refuse;
   wire long_wait = erase_active_i;
   wire rec_done  = state_r == flash_cmd_pkg::ST_RECOVER && rec_cnt_r == 24'd0;

   ////////////////////////////////////////////////////////////
   // arming / recovery state machine
   always_comb begin
      state_nxt   = state_r;
      rec_cnt_nxt = rec_cnt_r;
      case (state_r)
         flash_cmd_pkg::ST_IDLE: begin
            if (is_arm) begin
               state_nxt = flash_cmd_pkg::ST_ARMED;
            end
         end
         flash_cmd_pkg::ST_ARMED: begin
            if (accept) begin
               state_nxt   = flash_cmd_pkg::ST_RECOVER;
               rec_cnt_nxt = long_wait ? 24'(ERASE_CYC - 1) : 24'(RECOVER_CYC - 1);
            end else if (live && !is_arm) begin
               state_nxt = flash_cmd_pkg::ST_IDLE;
            end
         end
         flash_cmd_pkg::ST_RECOVER: begin
            if (rec_done) begin
               state_nxt = flash_cmd_pkg::ST_IDLE;
            end else begin
               rec_cnt_nxt = rec_cnt_r - 24'd1;
            end
         end
         default: begin
            state_nxt = flash_cmd_pkg::ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_r   <= flash_cmd_pkg::ST_IDLE;
         rec_cnt_r <= 24'd0;
      end else begin
         state_r   <= state_nxt;
         rec_cnt_r <= rec_cnt_nxt;
      end
   end

   ////////////////////////////////////////////////////////////
   // mode and volatile settings
   always_ff @(posedge clk_i) begin
      if (rst_i || accept) begin
         quad_mode_o <= 1'b0;
         settings_o  <= '{status: `STATUS_RESET,
                          write_enable_latch: 1'b0,
                          suspend_status_bit: 1'b0,
                          read_parameter_field: `READ_PARAM_RESET,
                          continuous_read_mode_byte: `CONT_MODE_RESET,
                          wrap_setting_bits: `WRAP_RESET,
                          deep_power_down: 1'b0};
      end else begin
         if (q_enter) begin
            quad_mode_o <= 1'b1;
         end else if (q_exit) begin
            quad_mode_o <= 1'b0;
         end
         // mode changes leave settings alone
         if (load_settings_i) begin
            settings_o <= settings_i;
         end else begin
            if (set_write_enable_latch_i) begin
               settings_o.write_enable_latch <= 1'b1;
            end
            if (set_suspend_status_bit_i) begin
               settings_o.suspend_status_bit <= 1'b1;
            end
         end
      end
   end

   // abort pulse and corruption flag
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         abort_o          <= 1'b0;
         integrity_lost_o <= 1'b0;
      end else begin
         abort_o <= accept;
         if (accept && (busy_i || settings_o.suspend_status_bit)) begin
            integrity_lost_o <= 1'b1;
         end
      end
   end

   // commands forwarded to the rest unless recovering or refused
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cmd_valid_o  <= 1'b0;
         cmd_opcode_o <= 8'h00;
      end else begin
         cmd_valid_o  <= live && !refused;
         cmd_opcode_o <= cmd.opcode;
      end
   end

   assign recovering_o  = state_r == flash_cmd_pkg::ST_RECOVER;
   assign erased_byte_o = `ARRAY_ERASED;

   ////////////////////////////////////////////////////////////
   // checks
   sequence s_armed_go;
      state_r == flash_cmd_pkg::ST_ARMED ##0 is_go;
   endsequence

   AST_EXIT_SPI: assert property (@(posedge clk_i) disable iff (rst_i)
      q_exit |=> !quad_mode_o) else $error("quad exit did not leave quad mode");
   AST_WEL_KEPT: assert property (@(posedge clk_i) disable iff (rst_i)
      (q_exit || q_enter) && !accept && !load_settings_i && !set_write_enable_latch_i |=>
      settings_o.write_enable_latch == $past(settings_o.write_enable_latch))
      else $error("mode change altered latch");
   AST_ABORT: assert property (@(posedge clk_i) disable iff (rst_i)
      accept |=> abort_o ##1 !abort_o) else $error("abort not one pulse");
   AST_CLEAR: assert property (@(posedge clk_i) disable iff (rst_i)
      accept |=> settings_o.wrap_setting_bits == `WRAP_RESET && !settings_o.write_enable_latch
      && !quad_mode_o) else $error("reset left settings");
   AST_ARM_GO: assert property (@(posedge clk_i) disable iff (rst_i)
      s_armed_go |=> recovering_o)
      else $error("armed reset not accepted");
   AST_RECOVER_LEN: assert property (@(posedge clk_i) disable iff (rst_i)
      accept && !long_wait |=> recovering_o[*2]) else $error("recovery ended early");
   AST_IGNORE: assert property (@(posedge clk_i) disable iff (rst_i)
      recovering_o |=> !cmd_valid_o) else $error("command passed during recovery");
   AST_QE_GATE: assert property (@(posedge clk_i) disable iff (rst_i)
      !quad_mode_o && !qe_sync_r[1] |=> !quad_mode_o) else $error("quad entered without enable");
   AST_NO_ARM: assert property (@(posedge clk_i) disable iff (rst_i)
      is_go && state_r == flash_cmd_pkg::ST_IDLE |=> !recovering_o) else $error("unarmed reset accepted");
endmodule

// [tb/host_model.sv]
`timescale 1ns/10ps

// host end of the link; the clock stands low between frames
module host_model (
   // link pins
   output logic       sclk_o,
   output logic       cs_n_o,
   output logic [3:0] io_o
);
   initial begin
      sclk_o = 1'b0;
      cs_n_o = 1'b1;
      io_o   = 4'h5;
   end

   // one opcode per frame, msb first; fewer than 8 bits makes a runt frame
   task automatic send(input logic [7:0] op, input logic quad, input int nbits);
      logic [7:0] sh;
      int         i;
      #7;
      cs_n_o = 1'b0;
      for (i = 0; i < nbits; i += (quad ? 4 : 1)) begin
         sh     = op << i;
         io_o   = quad ? sh[7:4] : {~io_o[3:1], sh[7]};
         #24 sclk_o = 1'b1;
         #24 sclk_o = 1'b0;
      end
      #12 cs_n_o = 1'b1;
      // released lines must not keep the last value
      io_o = ~io_o;
   endtask
endmodule

// [tb/tb.sv]
`timescale 1ns/10ps

module tb;
   localparam int RC = 40;
   localparam int EC = 50;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic sclk, cs_n, qe, busy, erase, set_wel, set_sus, load;
   logic [3:0] io;
   logic quad_mode_o, abort_o, recovering_o, cmd_valid_o, integrity_lost_o;
   logic [7:0] cmd_opcode_o, erased_byte_o;
   flash_cmd_pkg::volatile_t settings_o, ld, ex, rst_v;
   int error_cnt = 0;
   int checked = 0;
   int abort_cnt = 0;
   int rec_cnt = 0;

   always #50 clk_i = ~clk_i;

   host_model u_host_model (.sclk_o(sclk), .cs_n_o(cs_n), .io_o(io));

   flash_qpi_reset_ctl #(.RECOVER_CYC(RC), .ERASE_CYC(EC)) u_flash_qpi_reset_ctl (
      .clk_i(clk_i), .rst_i(rst_i), .sclk_i(sclk), .cs_n_i(cs_n), .io_i(io),
      .quad_enable_bit_i(qe), .busy_i(busy), .erase_active_i(erase),
      .set_write_enable_latch_i(set_wel), .set_suspend_status_bit_i(set_sus),
      .load_settings_i(load), .settings_i(ld), .quad_mode_o(quad_mode_o),
      .settings_o(settings_o), .abort_o(abort_o), .recovering_o(recovering_o),
      .cmd_valid_o(cmd_valid_o), .cmd_opcode_o(cmd_opcode_o),
      .integrity_lost_o(integrity_lost_o), .erased_byte_o(erased_byte_o));

   // pulse and recovery length counters
   always @(posedge clk_i) begin
      if (abort_o === 1'b1) abort_cnt <= abort_cnt + 1;
      if (recovering_o === 1'b1) rec_cnt <= rec_cnt + 1;
   end

   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e) begin
         error_cnt++;
         $display("unexpected %s: expected %h seen %h", n, e, g);
      end
   endtask

   task automatic print_verdict();
      $display("checked %0d error_cnt %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask

   // one frame, then a bounded look for the one-cycle command pulse
   task automatic frame(input logic [7:0] op, input logic q, input int nb, input logic e);
      logic seen;
      int   i;
      seen = 1'b0;
      u_host_model.send(op, q, nb);
      for (i = 0; i < 16 && !seen; i++) begin
         @(negedge clk_i);
         seen = (cmd_valid_o === 1'b1);
      end
      chk("cmd_valid", e, seen);
      if (seen) chk("cmd_opcode", op, cmd_opcode_o);
      if (e && !seen) print_verdict();
      repeat (6) @(negedge clk_i);
   endtask

   task automatic rec_wait(input int len);
      int n;
      for (n = 0; n < 200 && recovering_o !== 1'b0; n++) @(negedge clk_i);
      if (n == 200) begin
         error_cnt++;
         print_verdict();
      end
      chk("rec_len", len, rec_cnt);
   endtask

   task automatic pulse(ref logic s);
      @(negedge clk_i) s = 1'b1;
      @(negedge clk_i) s = 1'b0;
   endtask

   ////////////////////////////////////////////////////////////////////////
   initial begin
      {qe, busy, erase, set_wel, set_sus, load} = 6'h00;
      rst_v = '{8'h00, 1'b0, 1'b0, 8'h00, 8'h00, 3'h7, 1'b0};
      ld    = '{8'h5a, 1'b0, 1'b0, 8'h3c, 8'ha5, 3'h2, 1'b0};
      repeat (16) @(negedge clk_i);
      rst_i = 1'b0;
      @(negedge clk_i);
      chk("settings", rst_v, settings_o);
      chk("erased_byte", 8'hff, erased_byte_o);
      chk("integrity", 0, integrity_lost_o);
      $display("test delivery done");
      frame(8'h38, 0, 8, 0);
      chk("quad_mode", 0, quad_mode_o);
      qe = 1'b1;
      frame(8'h38, 0, 8, 1);
      chk("quad_mode", 1, quad_mode_o);
      $display("test quad entry done");
      pulse(load);
      pulse(set_wel);
      pulse(set_sus);
      ex = ld;
      ex.write_enable_latch = 1'b1;
      ex.suspend_status_bit = 1'b1;
      frame(8'hff, 1, 8, 1);
      chk("quad_mode", 0, quad_mode_o);
      chk("settings", ex, settings_o);
      $display("test quad exit done");
      frame(8'h38, 0, 8, 1);
      busy = 1'b1;
      frame(8'h66, 1, 8, 1);
      rec_cnt = 0;
      frame(8'h99, 1, 8, 1);
      chk("abort_cnt", 1, abort_cnt);
      chk("settings", rst_v, settings_o);
      chk("integrity", 1, integrity_lost_o);
      frame(8'h38, 0, 8, 0);
      chk("quad_mode", 0, quad_mode_o);
      rec_wait(RC);
      $display("test quad reset done");
      busy = 1'b0;
      erase = 1'b1;
      frame(8'h66, 0, 8, 1);
      frame(8'h06, 0, 8, 1);
      frame(8'h99, 0, 8, 0);
      frame(8'h99, 0, 4, 0);
      chk("abort_cnt", 1, abort_cnt);
      frame(8'h66, 0, 8, 1);
      frame(8'h66, 0, 8, 1);
      rec_cnt = 0;
      frame(8'h99, 0, 8, 1);
      chk("abort_cnt", 2, abort_cnt);
      rec_wait(EC);
      $display("test spi reset done");
      print_verdict();
   end
endmodule
